// [common/fsie_pkg.sv]
// Package: register map, field layout, reset values and types of the fiber status block
package fsie_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL1  = 6'h10;
  localparam logic [5:0] IDX_STATUS = 6'h11;
  localparam logic [5:0] IDX_EVEN   = 6'h12;
  localparam logic [5:0] IDX_ISTAT  = 6'h13;
  localparam logic [5:0] IDX_ICLR   = 6'h14;
  localparam logic [5:0] IDX_CTRL2  = 6'h1a;
  // Status register field positions
  localparam int ST_SPEED_LO = 14;
  localparam int ST_DUPLEX   = 13;
  localparam int ST_PAGE     = 12;
  localparam int ST_RESOLVED = 11;
  localparam int ST_LINK     = 10;
  localparam int ST_RF_LO    = 6;
  localparam int ST_SYNC     = 5;
  localparam int ST_ENERGY   = 4;
  localparam int ST_TXP      = 3;
  localparam int ST_RXP      = 2;
  // Event bit positions, shared by enable, status and clear registers
  localparam int EV_SPEED  = 14;
  localparam int EV_DUPLEX = 13;
  localparam int EV_PAGE   = 12;
  localparam int EV_ANDONE = 11;
  localparam int EV_LINK   = 10;
  localparam int EV_SYMERR = 9;
  localparam int EV_FCAR   = 8;
  localparam int EV_FIFO   = 7;
  localparam int EV_RFAULT = 5;
  localparam int EV_ENERGY = 4;
  localparam logic [15:0] EV_MASK      = 16'h7fb0;
  localparam logic [15:0] EV_SWCLR     = 16'h0020;
  localparam logic [15:0] EV_EN_RST    = 16'h0000;
  // Control fields
  localparam int C1_SWRST  = 15;
  localparam int C1_AN_EN  = 12;
  localparam int C1_DUPLEX = 8;
  localparam int C2_FORCE  = 15;
  localparam int C2_NORES  = 5;
  localparam logic [15:0] C1_MASK = 16'h9103;
  localparam logic [15:0] C2_MASK = 16'h8020;
  localparam logic [15:0] C1_RST  = 16'h1001;
  localparam logic [15:0] C2_RST  = 16'h0000;
  localparam logic        ENERGY_RST = 1'b1;
  localparam logic [1:0]  SPEED_100  = 2'h1;
  // Fiber interface modes
  typedef enum logic [1:0] {MODE_FX, MODE_1000X, MODE_SGMII_SYS, MODE_SGMII_MED} fsie_mode_t;
  // Bus answer states
  typedef enum logic {BUS_IDLE, BUS_ACK} fsie_bus_st_t;
  // Live conditions from the fiber receive path
  typedef struct packed {
    logic [1:0] res_speed;
    logic       res_duplex;
    logic       res_tx_pause;
    logic       res_rx_pause;
    logic       an_complete;
    logic       link_up;
    logic       page_rx;
    logic [1:0] rf_code;
    logic       sync_ok;
    logic       energy_present;
    logic       symbol_err;
    logic       false_carrier;
    logic       fifo_err;
  } fsie_phy_in_t;
endpackage

// [core/fsie_core.sv]
// Fiber status and interrupt enable register bank with Avalon-MM slave
// Notes on behaviour
// - Speed field reports resolved speed; fixed 01 in 100BASE-FX mode.
// - Duplex bit reports resolved duplex; follows forced duplex bit in 100BASE-FX.
// - Resolved bit set on negotiation complete or negotiation disabled.
// - Resolved reads 1 when negotiation off or in 100BASE-FX mode.
// - Resolve-block control bit forces resolved to 0 above everything.
// - Page received latches high; always 0 in 100BASE-FX mode.
// - Energy status reads 1 with no energy; comes out of reset as 1.
// - Remote fault code latches high: 00 none, 01 link fail, 10 offline, 11 error.
// - Transmit pause shows resolved outcome only; 0 in 100BASE-FX.
// - Receive pause shows resolved outcome only; 0 in 100BASE-FX.
// - Enable register has bits 14..7, 5, 4 writable; others read 0.
// - Each enabled event has a sticky status bit recording it.
// - Force-interrupt bit asserts the interrupt output regardless of events.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/100ps
module fsie_core (
  // Clock, reset, enable
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // Avalon-MM slave
  input  wire logic [7:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  output logic      [31:0]           readdata,
  output logic                       waitrequest,
  // Fiber receive path conditions
  input  wire fsie_pkg::fsie_phy_in_t phy_in,
  // Interrupt, active low
  output logic                       irq_out_low
);

  // Register word match for a byte address
  function automatic logic idx_hit(input logic [7:0] a, input logic [5:0] idx);
    return a[7:2] == idx && a[1:0] == 2'h0;
  endfunction

  fsie_pkg::fsie_bus_st_t bus_st_reg;
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [15:0] ctrl1_reg;
  logic [15:0] ctrl2_reg;
  logic [15:0] even_reg;
  logic [15:0] istat_reg;
  logic        page_lat_reg;
  logic [1:0]  rf_lat_reg;
  logic        energy_reg;
  logic        irq_low_reg;
  fsie_pkg::fsie_phy_in_t prev_reg;
  logic [15:0] status_live;
  logic [15:0] ev_now;
  logic        fx_mode;
  logic        resolved;
  logic        req;
  logic        acc;
  logic        acc_wr;
  logic        rd_status;
  logic        sw_rst;
  logic [15:0] wdata16;
  logic [15:0] rd_mux;

  assign req       = read | write;
  assign acc       = ce && req && bus_st_reg == fsie_pkg::BUS_ACK;
  assign acc_wr    = acc && write;
  assign rd_status = acc && read && idx_hit(address, fsie_pkg::IDX_STATUS);
  assign wdata16   = writedata[15:0];
  assign sw_rst    = acc_wr && idx_hit(address, fsie_pkg::IDX_CTRL1) && wdata16[fsie_pkg::C1_SWRST];
  assign fx_mode   = ctrl1_reg[1:0] == 2'(fsie_pkg::MODE_FX);

  // Bus answer: one wait cycle, then waitrequest low for one cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_st_reg <= fsie_pkg::BUS_IDLE;
      wait_reg   <= 1'b1;
    end else if (ce) begin
      case (bus_st_reg)
        fsie_pkg::BUS_IDLE: begin
          if (req) begin
            bus_st_reg <= fsie_pkg::BUS_ACK;
            wait_reg   <= 1'b0;
          end
        end
        fsie_pkg::BUS_ACK: begin
          bus_st_reg <= fsie_pkg::BUS_IDLE;
          wait_reg   <= 1'b1;
        end
        default: begin
          bus_st_reg <= fsie_pkg::BUS_IDLE;
          wait_reg   <= 1'b1;
        end
      endcase
    end
  end

  // Resolved flag from negotiation state and overrides
  always_comb begin
    if (ctrl2_reg[fsie_pkg::C2_NORES]) begin
      resolved = 1'b0;
    end else if (!ctrl1_reg[fsie_pkg::C1_AN_EN] || fx_mode) begin
      resolved = 1'b1;
    end else begin
      resolved = phy_in.an_complete;
    end
  end

  // Live status word
  always_comb begin
    status_live = 16'h0000;
    status_live[fsie_pkg::ST_SPEED_LO +: 2] = fx_mode ? fsie_pkg::SPEED_100 : phy_in.res_speed;
    status_live[fsie_pkg::ST_DUPLEX] = fx_mode ? ctrl1_reg[fsie_pkg::C1_DUPLEX]
                                               : phy_in.res_duplex;
    status_live[fsie_pkg::ST_PAGE]     = page_lat_reg && !fx_mode;
    status_live[fsie_pkg::ST_RESOLVED] = resolved;
    status_live[fsie_pkg::ST_LINK]     = phy_in.link_up;
    status_live[fsie_pkg::ST_RF_LO +: 2] = rf_lat_reg;
    status_live[fsie_pkg::ST_SYNC]       = phy_in.sync_ok;
    status_live[fsie_pkg::ST_ENERGY] = energy_reg;
    status_live[fsie_pkg::ST_TXP] = phy_in.res_tx_pause && !fx_mode;
    status_live[fsie_pkg::ST_RXP] = phy_in.res_rx_pause && !fx_mode;
  end

  // Energy status flop; starts as no energy until the line is first seen
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      energy_reg <= fsie_pkg::ENERGY_RST;
    end else if (ce) begin
      energy_reg <= sw_rst ? fsie_pkg::ENERGY_RST : !phy_in.energy_present;
    end
  end

  // Latching-high bits; a new event in the read cycle wins over the clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      page_lat_reg <= 1'b0;
      rf_lat_reg   <= 2'h0;
    end else if (ce) begin
      if (sw_rst) begin
        page_lat_reg <= 1'b0;
        rf_lat_reg   <= 2'h0;
      end else if (rd_status) begin
        page_lat_reg <= phy_in.page_rx;
        rf_lat_reg   <= phy_in.rf_code;
      end else begin
        page_lat_reg <= page_lat_reg | phy_in.page_rx;
        if (phy_in.rf_code != 2'h0) begin
          rf_lat_reg <= phy_in.rf_code;
        end
      end
    end
  end

  // Previous inputs for change detection
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_reg <= '0;
    end else if (ce) begin
      prev_reg <= phy_in;
    end
  end

  // Event pulses in enable-register layout
  always_comb begin
    ev_now = 16'h0000;
    ev_now[fsie_pkg::EV_SPEED]  = phy_in.res_speed != prev_reg.res_speed;
    ev_now[fsie_pkg::EV_DUPLEX] = phy_in.res_duplex != prev_reg.res_duplex;
    ev_now[fsie_pkg::EV_PAGE]   = phy_in.page_rx && !fx_mode;
    ev_now[fsie_pkg::EV_ANDONE] = phy_in.an_complete && !prev_reg.an_complete;
    ev_now[fsie_pkg::EV_LINK]   = phy_in.link_up != prev_reg.link_up;
    ev_now[fsie_pkg::EV_SYMERR] = phy_in.symbol_err;
    ev_now[fsie_pkg::EV_FCAR]   = phy_in.false_carrier;
    ev_now[fsie_pkg::EV_FIFO]   = phy_in.fifo_err;
    ev_now[fsie_pkg::EV_RFAULT] = phy_in.rf_code != prev_reg.rf_code;
    ev_now[fsie_pkg::EV_ENERGY] = phy_in.energy_present != prev_reg.energy_present;
  end

  // Sticky event status; write-one-to-clear register, set beats clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      istat_reg <= 16'h0000;
    end else if (ce) begin
      if (sw_rst) begin
        istat_reg <= ev_now & fsie_pkg::EV_MASK;
      end else if (acc_wr && idx_hit(address, fsie_pkg::IDX_ICLR)) begin
        istat_reg <= ((istat_reg & ~wdata16) | ev_now) & fsie_pkg::EV_MASK;
      end else begin
        istat_reg <= (istat_reg | ev_now) & fsie_pkg::EV_MASK;
      end
    end
  end

  // Event enable register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      even_reg <= fsie_pkg::EV_EN_RST;
    end else if (ce) begin
      if (sw_rst) begin
        even_reg <= even_reg & ~fsie_pkg::EV_SWCLR;
      end else if (acc_wr && idx_hit(address, fsie_pkg::IDX_EVEN)) begin
        even_reg <= wdata16 & fsie_pkg::EV_MASK;
      end
    end
  end

  // Control registers; soft reset bit clears itself and retains the rest
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl1_reg <= fsie_pkg::C1_RST;
      ctrl2_reg <= fsie_pkg::C2_RST;
    end else if (ce && acc_wr) begin
      if (idx_hit(address, fsie_pkg::IDX_CTRL1)) begin
        ctrl1_reg <= wdata16 & fsie_pkg::C1_MASK & ~(16'h0001 << fsie_pkg::C1_SWRST);
      end
      if (idx_hit(address, fsie_pkg::IDX_CTRL2)) begin
        ctrl2_reg <= wdata16 & fsie_pkg::C2_MASK;
      end
    end
  end

  // Read data mux; unmapped words read zero
  always_comb begin
    if (idx_hit(address, fsie_pkg::IDX_CTRL1)) begin
      rd_mux = ctrl1_reg;
    end else if (idx_hit(address, fsie_pkg::IDX_STATUS)) begin
      rd_mux = status_live;
    end else if (idx_hit(address, fsie_pkg::IDX_EVEN)) begin
      rd_mux = even_reg;
    end else if (idx_hit(address, fsie_pkg::IDX_ISTAT)) begin
      rd_mux = istat_reg;
    end else if (idx_hit(address, fsie_pkg::IDX_CTRL2)) begin
      rd_mux = ctrl2_reg;
    end else begin
      rd_mux = 16'h0000;
    end
  end

  // Read data captured on the same edge that waitrequest falls
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (ce && read && bus_st_reg == fsie_pkg::BUS_IDLE) begin
      rdata_reg <= {16'h0000, rd_mux};
    end
  end

  // Interrupt output, registered so it never glitches
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_low_reg <= 1'b1;
    end else if (ce) begin
      irq_low_reg <= !((|(istat_reg & even_reg)) || ctrl2_reg[fsie_pkg::C2_FORCE]);
    end
  end

  assign readdata    = rdata_reg;
  assign waitrequest = wait_reg;
  assign irq_out_low = irq_low_reg;

  // Named steps: a status read, and a page pulse seen outside any status read or soft reset
  sequence s_status_read;
    rd_status && !sw_rst;
  endsequence

  sequence s_page_seen;
    ce && phy_in.page_rx && !rd_status && !sw_rst;
  endsequence

  AST_SPEED_FX: assert property (@(posedge sys_clk) disable iff (rst)
    fx_mode |-> status_live[fsie_pkg::ST_SPEED_LO +: 2] == fsie_pkg::SPEED_100)
    else $error("speed not 01 in fx mode");

  AST_DUPLEX_FX: assert property (@(posedge sys_clk) disable iff (rst)
    fx_mode |-> status_live[fsie_pkg::ST_DUPLEX] == ctrl1_reg[fsie_pkg::C1_DUPLEX])
    else $error("fx duplex not following control");

  AST_RES_DONE: assert property (@(posedge sys_clk) disable iff (rst)
    (phy_in.an_complete && !ctrl2_reg[fsie_pkg::C2_NORES]) |-> status_live[fsie_pkg::ST_RESOLVED])
    else $error("resolved missing after negotiation");

  AST_RES_NOAN: assert property (@(posedge sys_clk) disable iff (rst)
    (!ctrl1_reg[fsie_pkg::C1_AN_EN] && !ctrl2_reg[fsie_pkg::C2_NORES])
      |-> status_live[fsie_pkg::ST_RESOLVED])
    else $error("resolved low with negotiation off");

  AST_RES_BLOCK: assert property (@(posedge sys_clk) disable iff (rst)
    ctrl2_reg[fsie_pkg::C2_NORES] |-> !status_live[fsie_pkg::ST_RESOLVED])
    else $error("resolved high while blocked");

  AST_PAGE_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    s_page_seen ##1 (!rd_status && !sw_rst)[*2] |-> page_lat_reg)
    else $error("page latch lost");

  AST_ENERGY: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && !sw_rst) |=> energy_reg == !$past(phy_in.energy_present))
    else $error("energy status not inverted");

  AST_RF_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && rf_lat_reg != 2'h0 && !rd_status && !sw_rst) |=> rf_lat_reg != 2'h0)
    else $error("fault code dropped without read");

  AST_PAUSE_FX: assert property (@(posedge sys_clk) disable iff (rst)
    fx_mode |-> {status_live[fsie_pkg::ST_TXP], status_live[fsie_pkg::ST_RXP]} == 2'h0)
    else $error("pause shown in fx mode");

  AST_EN_RSVD: assert property (@(posedge sys_clk) disable iff (rst)
    (even_reg & ~fsie_pkg::EV_MASK) == 16'h0000)
    else $error("reserved enable bit set");

  AST_SWRST_EN: assert property (@(posedge sys_clk) disable iff (rst)
    sw_rst |=> even_reg == ($past(even_reg) & ~fsie_pkg::EV_SWCLR))
    else $error("soft reset altered retained enables");

  AST_READ_CLR: assert property (@(posedge sys_clk) disable iff (rst)
    s_status_read |=> page_lat_reg == $past(phy_in.page_rx))
    else $error("latch not restored to live on read");

  AST_STICKY: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && ev_now[fsie_pkg::EV_LINK]) |=> istat_reg[fsie_pkg::EV_LINK])
    else $error("link event not recorded");

  AST_FORCE_IRQ: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && ctrl2_reg[fsie_pkg::C2_FORCE]) |=> !irq_out_low)
    else $error("forced interrupt not asserted");

  AST_BUS_ANS: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && req && wait_reg && bus_st_reg == fsie_pkg::BUS_IDLE) |=> !waitrequest)
    else $error("no answer one cycle after request");

endmodule // fsie_core

// [verif/fsie_tb.sv]
// Self-checking testbench for the fiber status and event enable register bank
`timescale 1ns/100ps
module testbench;
  // Stimulus, design outputs and bookkeeping
  logic                   sys_clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   ce = 1'b1;
  logic [7:0]             address = 8'h00;
  logic                   read = 1'b0;
  logic                   write = 1'b0;
  logic [31:0]            writedata = 32'h0;
  logic [31:0]            readdata;
  logic                   waitrequest;
  fsie_pkg::fsie_phy_in_t phy_in = '0;
  logic                   irq_out_low;
  int                     num_errors = 0;
  int                     total_checks = 0;
  int                     cycles = 0;
  logic [15:0]            rd;
  logic [31:0]            r;
  logic [15:0]            c1;
  logic [15:0]            c2;
  fsie_pkg::fsie_phy_in_t p;
  // Sticky bit expected for each event input, in the order the event test drives them
  int                     ev_pos [10] = '{fsie_pkg::EV_SPEED, fsie_pkg::EV_DUPLEX,
                                          fsie_pkg::EV_PAGE, fsie_pkg::EV_ANDONE,
                                          fsie_pkg::EV_LINK, fsie_pkg::EV_SYMERR,
                                          fsie_pkg::EV_FCAR, fsie_pkg::EV_FIFO,
                                          fsie_pkg::EV_RFAULT, fsie_pkg::EV_ENERGY};

  fsie_core u_dut (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .ce          (ce),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .phy_in      (phy_in),
    .irq_out_low (irq_out_low)
  );

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      $display("ERROR %0t timeout", $time);
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One Avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
    @(posedge sys_clk);
    address <= {idx, 2'b00};
    read <= ~wr;
    write <= wr;
    writedata <= {16'h0000, wd};
    // Ends when waitrequest is sampled low; the hang guard covers a bus that never answers
    do begin
      @(posedge sys_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata[15:0];
    read <= 1'b0;
    write <= 1'b0;
    if (!wr) begin
      chk(readdata[31:16], 16'h0000, "upper half zero");
    end
  endtask

  // Reference status word from live inputs and control settings
  function automatic logic [15:0] exp_st(fsie_pkg::fsie_phy_in_t q, logic [15:0] k1,
                                         logic [15:0] k2);
    logic        fx;
    logic [15:0] e;
    fx = (k1[1:0] == 2'b00);
    e = 16'h0000;
    e[15:14] = fx ? 2'h1 : q.res_speed;
    e[13] = fx ? k1[8] : q.res_duplex;
    e[12] = fx ? 1'b0 : q.page_rx;
    e[11] = k2[5] ? 1'b0 : ((fx || !k1[12]) ? 1'b1 : q.an_complete);
    e[10] = q.link_up;
    e[7:6] = q.rf_code;
    e[5] = q.sync_ok;
    e[4] = ~q.energy_present;
    e[3] = fx ? 1'b0 : q.res_tx_pause;
    e[2] = fx ? 1'b0 : q.res_rx_pause;
    return e;
  endfunction

  // Irq pin after the two-cycle path settles
  task automatic irq_is(input logic lvl);
    repeat (3) @(posedge sys_clk);
    chk({15'h0000, irq_out_low}, {15'h0000, lvl}, "irq level");
  endtask

  // Main sequence
  initial begin
    r = $urandom(32'h1cf1);
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, fsie_pkg::IDX_STATUS, 16'h0000);
    chk(rd, exp_st('0, fsie_pkg::C1_RST, fsie_pkg::C2_RST), "status reset");
    bus(1'b0, fsie_pkg::IDX_EVEN, 16'h0000);
    chk(rd, 16'h0000, "enable reset");
    bus(1'b0, 6'h3f, 16'h0000);
    chk(rd, 16'h0000, "unmapped read");
    $display("reset test done");
    // Writable enable bits only; reserved bits stay 0
    for (int i = 0; i < 4; i++) begin
      r = (i == 0) ? 32'hffff : $urandom;
      bus(1'b1, fsie_pkg::IDX_EVEN, r[15:0]);
      bus(1'b0, fsie_pkg::IDX_EVEN, 16'h0000);
      chk(rd, r[15:0] & 16'h7fb0, "enable rw");
    end
    $display("enable test done");
    // Every mode, negotiation on and off, resolve block on and off
    for (int i = 0; i < 32; i++) begin
      r = $urandom;
      c1 = 16'h0000;
      c1[1:0] = i[1:0];
      c1[12] = i[2];
      c1[8] = r[20];
      c2 = {10'h000, i[3], 5'h00};
      p = fsie_pkg::fsie_phy_in_t'(r[$bits(fsie_pkg::fsie_phy_in_t)-1:0]);
      bus(1'b1, fsie_pkg::IDX_CTRL1, c1);
      bus(1'b1, fsie_pkg::IDX_CTRL2, c2);
      phy_in <= p;
      bus(1'b0, fsie_pkg::IDX_STATUS, 16'h0000);
      bus(1'b0, fsie_pkg::IDX_STATUS, 16'h0000);
      chk(rd, exp_st(p, c1, c2), "status fields");
    end
    $display("status test done");
    // Short page and fault pulses must hold until read
    bus(1'b1, fsie_pkg::IDX_CTRL1, 16'h1001);
    bus(1'b1, fsie_pkg::IDX_CTRL2, 16'h0000);
    phy_in <= '0;
    bus(1'b0, fsie_pkg::IDX_STATUS, 16'h0000);
    for (int k = 1; k < 4; k++) begin
      @(posedge sys_clk);
      phy_in.page_rx <= 1'b1;
      phy_in.rf_code <= k[1:0];
      @(posedge sys_clk);
      phy_in <= '0;
      repeat (3) @(posedge sys_clk);
      bus(1'b0, fsie_pkg::IDX_STATUS, 16'h0000);
      chk(rd & 16'h10c0, 16'h1000 | (k[15:0] << 6), "latched");
      bus(1'b0, fsie_pkg::IDX_STATUS, 16'h0000);
      chk(rd & 16'h10c0, 16'h0000, "after read");
    end
    $display("latch test done");
    // Masked event, late enable, clear and forced interrupt
    bus(1'b1, fsie_pkg::IDX_EVEN, 16'h0000);
    bus(1'b1, fsie_pkg::IDX_ICLR, 16'hffff);
    @(posedge sys_clk);
    phy_in.symbol_err <= 1'b1;
    @(posedge sys_clk);
    phy_in.symbol_err <= 1'b0;
    irq_is(1'b1);
    bus(1'b1, fsie_pkg::IDX_EVEN, 16'h0200);
    irq_is(1'b0);
    bus(1'b0, fsie_pkg::IDX_ISTAT, 16'h0000);
    chk(rd & 16'h0200, 16'h0200, "event recorded");
    bus(1'b1, fsie_pkg::IDX_ICLR, 16'h0200);
    irq_is(1'b1);
    bus(1'b1, fsie_pkg::IDX_CTRL2, 16'h8000);
    irq_is(1'b0);
    bus(1'b1, fsie_pkg::IDX_CTRL2, 16'h0000);
    irq_is(1'b1);
    $display("interrupt test done");
    // Soft reset drops only the remote fault enable
    bus(1'b1, fsie_pkg::IDX_EVEN, 16'hffff);
    bus(1'b1, fsie_pkg::IDX_CTRL1, 16'h9001);
    bus(1'b0, fsie_pkg::IDX_EVEN, 16'h0000);
    chk(rd, 16'h7f90, "soft reset enables");
    $display("soft reset test done");
    // Hardware reset in mid-run clears every enable
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, fsie_pkg::IDX_EVEN, 16'h0000);
    chk(rd, fsie_pkg::EV_EN_RST, "enable after reset");
    bus(1'b0, fsie_pkg::IDX_STATUS, 16'h0000);
    chk(rd, exp_st('0, fsie_pkg::C1_RST, fsie_pkg::C2_RST), "status after reset");
    $display("hardware reset test done");
    // Each event input sets its own sticky bit; change events fire on both edges
    for (int k = 0; k < 10; k++) begin
      p = '0;
      case (k)
        0: p.res_speed = 2'h2;
        1: p.res_duplex = 1'b1;
        2: p.page_rx = 1'b1;
        3: p.an_complete = 1'b1;
        4: p.link_up = 1'b1;
        5: p.symbol_err = 1'b1;
        6: p.false_carrier = 1'b1;
        7: p.fifo_err = 1'b1;
        8: p.rf_code = 2'h1;
        default: p.energy_present = 1'b1;
      endcase
      bus(1'b1, fsie_pkg::IDX_ICLR, 16'hffff);
      @(posedge sys_clk);
      phy_in <= p;
      @(posedge sys_clk);
      phy_in <= '0;
      repeat (2) @(posedge sys_clk);
      bus(1'b0, fsie_pkg::IDX_ISTAT, 16'h0000);
      chk(rd, 16'h0001 << ev_pos[k], "event bit");
    end
    $display("event test done");
    // Clock enable low freezes all state, so an event in that cycle is lost
    bus(1'b1, fsie_pkg::IDX_EVEN, 16'h0200);
    bus(1'b1, fsie_pkg::IDX_ICLR, 16'hffff);
    @(posedge sys_clk);
    ce <= 1'b0;
    phy_in.symbol_err <= 1'b1;
    @(posedge sys_clk);
    ce <= 1'b1;
    phy_in.symbol_err <= 1'b0;
    irq_is(1'b1);
    bus(1'b0, fsie_pkg::IDX_ISTAT, 16'h0000);
    chk(rd, 16'h0000, "frozen event");
    $display("clock enable test done");
    close_out();
  end
endmodule // testbench
